// File: qsfr_defines.svh
// qsfr_defines.svh: constants for the serial flash read engine.
// assumes: included by bare name from the engine's design files.
`ifndef QSFR_DEFINES_SVH
`define QSFR_DEFINES_SVH

// ==========================================================
// frame layout
`define QSFR_HDR_LAST     8'h1f   // command byte + 24 address bits
`define QSFR_END_LAST     8'h03   // four half periods = two periods
`define QSFR_MM_LEN_M1    7'h1f   // memory window reads 32-bit words
`define QSFR_MM_CNT_M1    12'h000 // one word per window read

// ==========================================================
// idle levels
`define QSFR_SCLK_IDLE    1'b0    // clock polarity zero
`define QSFR_CS_IDLE      1'b1    // chip select is active low

`endif

// File: qsfr_pkg.sv
// qsfr_pkg.sv: types shared by the serial flash read engine.
// assumes: nothing; compiled before the design modules.
package qsfr_pkg;

	// ==========================================================
	// link-side sequencer states
	typedef enum logic [6:0] {
		ST_IDLE  = 7'h01,
		ST_SETUP = 7'h02,
		ST_HDR   = 7'h04,
		ST_DUMMY = 7'h08,
		ST_DATA  = 7'h10,
		ST_HOLD  = 7'h20,
		ST_END   = 7'h40
	} qsfr_state_t;

	// ==========================================================
	// read width and pin configuration
	typedef enum logic [1:0] {
		LANE_X1 = 2'h0,
		LANE_X2 = 2'h1,
		LANE_X4 = 2'h2
	} qsfr_lane_t;

	typedef enum logic [1:0] {
		PINS_3 = 2'h0,
		PINS_4 = 2'h1,
		PINS_6 = 2'h2
	} qsfr_pins_t;

endpackage : qsfr_pkg

// File: qsfr_sync.sv
// qsfr_sync.sv: two-flop synchroniser, one independent bit per lane.
// assumes: each bit is a level or a toggle, never a multi-bit word.
module qsfr_sync #(
	parameter int W = 1
) (
	input  wire logic         clock,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// first stage feeds only the second stage
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;

endmodule : qsfr_sync

// File: qsfr_top.sv
// qsfr_top.sv: serial flash read engine, controller side only.
// assumes: config ports stay stable while busy is high; the flash
// launches data on falling sclk; link_clock runs free.
//
// Overview of operation
// - always the controller; chip select and clock are always driven.
// - reads over one, two or four data lines as configured.
// - a memory window read becomes a serial read with no software steps.
// - word length programmable from 1 to 128 bits.
// - words per frame programmable from 1 to 4096.
// - optional event per completed word or per completed frame.
// - chip select to first data delay of 0 to 3 clock periods.
// - 3-, 4- and 6-pin configurations use only their own lines.
// - clock mode 0: clock idles low, phase zero.
// - read data is captured on the falling clock edge.
// - outgoing line zero changes after the falling clock edge.
// - chip select released two periods after the final falling edge.
// - chip select leads the first falling edge by delay plus one periods.
`include "qsfr_defines.svh"

module qsfr_top (
	input  wire logic         clock,
	input  wire logic         rst_n,
	input  wire logic         link_clock,
	input  wire logic [1:0]   lane_mode,
	input  wire logic [1:0]   pin_mode,
	input  wire logic [6:0]   word_len_m1,
	input  wire logic [11:0]  word_cnt_m1,
	input  wire logic [1:0]   cs_to_data_delay_field,
	input  wire logic [7:0]   clk_div,
	input  wire logic [3:0]   dummy_cycles,
	input  wire logic         word_irq_en,
	input  wire logic         frame_irq_en,
	input  wire logic         sw_start,
	input  wire logic [7:0]   sw_cmd,
	input  wire logic [23:0]  sw_addr,
	output logic              busy,
	output logic [127:0]      rx_word,
	output logic              rx_word_valid,
	output logic              word_irq,
	output logic              frame_irq,
	input  wire logic [7:0]   mm_cmd,
	input  wire logic         mm_req,
	input  wire logic [23:0]  mm_addr,
	output logic              mm_ready,
	output logic              mm_rvalid,
	output logic [31:0]       mm_rdata,
	output logic              cs_n,
	output logic              sclk,
	input  wire logic [3:0]   d_i,
	output logic [3:0]        d_o,
	output logic [3:0]        d_oe
);

	// ==========================================================
	// helper functions

	// narrower pin sets force single-line reads
	function automatic qsfr_pkg::qsfr_lane_t lane_sel(
		input logic [1:0] lanes,
		input logic [1:0] pins
	);
		lane_sel = qsfr_pkg::LANE_X1;
		if (pins == qsfr_pkg::PINS_6 && lanes == qsfr_pkg::LANE_X2) begin
			lane_sel = qsfr_pkg::LANE_X2;
		end
		if (pins == qsfr_pkg::PINS_6 && lanes == qsfr_pkg::LANE_X4) begin
			lane_sel = qsfr_pkg::LANE_X4;
		end
	endfunction : lane_sel

	function automatic logic [7:0] lane_bits(input qsfr_pkg::qsfr_lane_t l);
		unique case (l)
			qsfr_pkg::LANE_X2: lane_bits = 8'h02;
			qsfr_pkg::LANE_X4: lane_bits = 8'h04;
			default:           lane_bits = 8'h01;
		endcase
	endfunction : lane_bits

	// single-line reads: 3-pin on the shared line, others on line one
	function automatic logic [127:0] shift_in(
		input logic [127:0]         sh,
		input logic [3:0]           d,
		input qsfr_pkg::qsfr_lane_t l,
		input logic [1:0]           pins
	);
		unique case (l)
			qsfr_pkg::LANE_X2: shift_in = {sh[125:0], d[1:0]};
			qsfr_pkg::LANE_X4: shift_in = {sh[123:0], d[3:0]};
			default: begin
				if (pins == qsfr_pkg::PINS_3) begin
					shift_in = {sh[126:0], d[0]};
				end else begin
					shift_in = {sh[126:0], d[1]};
				end
			end
		endcase
	endfunction : shift_in

	// ==========================================================
	// declarations
	logic         busy_q, busy_d, mm_mode_q, mm_mode_d;
	logic         req_tgl_q, req_tgl_d, ack_tgl_q, ack_tgl_d;
	logic         word_seen_q, word_seen_d, done_seen_q, done_seen_d;
	logic [1:0]   lanes_q, lanes_d, pins_q, pins_d, dly_q, dly_d;
	logic [6:0]   len_q, len_d;
	logic [11:0]  cnt_q, cnt_d;
	logic [7:0]   div_q, div_d;
	logic [3:0]   dum_q, dum_d;
	logic [31:0]  hdr_q, hdr_d, mm_rdata_q, mm_rdata_d;
	logic [127:0] rx_word_q, rx_word_d;
	logic         rx_valid_q, rx_valid_d, mm_rvalid_q, mm_rvalid_d;
	logic         word_irq_q, word_irq_d, frame_irq_q, frame_irq_d;
	logic         word_s, done_s, req_s, ack_s;
	logic [3:0]   d_s;

	qsfr_pkg::qsfr_state_t lk_st_q, lk_st_d;
	logic         lk_req_seen_q, lk_req_seen_d, lk_sclk_q, lk_sclk_d;
	logic         lk_cs_n_q, lk_cs_n_d, lk_last_q, lk_last_d;
	logic         lk_word_tgl_q, lk_word_tgl_d, lk_done_tgl_q, lk_done_tgl_d;
	logic [7:0]   lk_half_q, lk_half_d, lk_bcnt_q, lk_bcnt_d;
	logic [11:0]  lk_wcnt_q, lk_wcnt_d;
	logic [31:0]  lk_hdr_q, lk_hdr_d;
	logic [127:0] lk_sh_q, lk_sh_d, lk_word_q, lk_word_d, lk_sh_n;
	logic [3:0]   lk_do_q, lk_do_d, lk_oe_q, lk_oe_d;
	logic         tick, fall;
	qsfr_pkg::qsfr_lane_t lk_lane;

	// ==========================================================
	// domain crossings
	qsfr_sync #(.W(2)) u_to_link (
		.clock    (link_clock),
		.rst_n    (rst_n),
		.async_in ({ack_tgl_q, req_tgl_q}),
		.sync_out ({ack_s, req_s})
	);

	qsfr_sync #(.W(2)) u_to_sys (
		.clock    (clock),
		.rst_n    (rst_n),
		.async_in ({lk_done_tgl_q, lk_word_tgl_q}),
		.sync_out ({done_s, word_s})
	);

	// pin data gets two flops before the capture logic
	qsfr_sync #(.W(4)) u_pins (
		.clock    (link_clock),
		.rst_n    (rst_n),
		.async_in (d_i),
		.sync_out (d_s)
	);

	// ==========================================================
	// system side: request launch and word hand-off

	// config is latched at launch so the link sees stable values
	always_comb begin
		busy_d      = busy_q;
		mm_mode_d   = mm_mode_q;
		req_tgl_d   = req_tgl_q;
		ack_tgl_d   = ack_tgl_q;
		word_seen_d = word_seen_q;
		done_seen_d = done_seen_q;
		lanes_d     = lanes_q;
		pins_d      = pins_q;
		dly_d       = dly_q;
		len_d       = len_q;
		cnt_d       = cnt_q;
		div_d       = div_q;
		dum_d       = dum_q;
		hdr_d       = hdr_q;
		rx_word_d   = rx_word_q;
		mm_rdata_d  = mm_rdata_q;
		rx_valid_d  = 1'b0;
		mm_rvalid_d = 1'b0;
		word_irq_d  = 1'b0;
		frame_irq_d = 1'b0;
		if (!busy_q && (mm_req || sw_start)) begin
			busy_d    = 1'b1;
			req_tgl_d = ~req_tgl_q;
			lanes_d   = lane_mode;
			pins_d    = pin_mode;
			dly_d     = cs_to_data_delay_field;
			div_d     = clk_div;
			dum_d     = dummy_cycles;
			if (mm_req) begin
				mm_mode_d = 1'b1;
				len_d     = `QSFR_MM_LEN_M1;
				cnt_d     = `QSFR_MM_CNT_M1;
				hdr_d     = {mm_cmd, mm_addr};
			end else begin
				mm_mode_d = 1'b0;
				len_d     = word_len_m1;
				cnt_d     = word_cnt_m1;
				hdr_d     = {sw_cmd, sw_addr};
			end
		end
		// link holds the word stable until this ack comes back
		if (word_s != word_seen_q) begin
			word_seen_d = word_s;
			ack_tgl_d   = ~ack_tgl_q;
			rx_word_d   = lk_word_q;
			rx_valid_d  = 1'b1;
			word_irq_d  = word_irq_en;
			frame_irq_d = frame_irq_en & lk_last_q;
			if (mm_mode_q && lk_last_q) begin
				mm_rvalid_d = 1'b1;
				mm_rdata_d  = lk_word_q[31:0];
			end
		end
		if (done_s != done_seen_q) begin
			done_seen_d = done_s;
			busy_d      = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			busy_q      <= 1'b0;
			mm_mode_q   <= 1'b0;
			req_tgl_q   <= 1'b0;
			ack_tgl_q   <= 1'b0;
			word_seen_q <= 1'b0;
			done_seen_q <= 1'b0;
			lanes_q     <= 2'h0;
			pins_q      <= 2'h0;
			dly_q       <= 2'h0;
			len_q       <= 7'h00;
			cnt_q       <= 12'h000;
			div_q       <= 8'h00;
			dum_q       <= 4'h0;
			hdr_q       <= 32'h0000_0000;
			rx_word_q   <= '0;
			mm_rdata_q  <= 32'h0000_0000;
			rx_valid_q  <= 1'b0;
			mm_rvalid_q <= 1'b0;
			word_irq_q  <= 1'b0;
			frame_irq_q <= 1'b0;
		end else begin
			busy_q      <= busy_d;
			mm_mode_q   <= mm_mode_d;
			req_tgl_q   <= req_tgl_d;
			ack_tgl_q   <= ack_tgl_d;
			word_seen_q <= word_seen_d;
			done_seen_q <= done_seen_d;
			lanes_q     <= lanes_d;
			pins_q      <= pins_d;
			dly_q       <= dly_d;
			len_q       <= len_d;
			cnt_q       <= cnt_d;
			div_q       <= div_d;
			dum_q       <= dum_d;
			hdr_q       <= hdr_d;
			rx_word_q   <= rx_word_d;
			mm_rdata_q  <= mm_rdata_d;
			rx_valid_q  <= rx_valid_d;
			mm_rvalid_q <= mm_rvalid_d;
			word_irq_q  <= word_irq_d;
			frame_irq_q <= frame_irq_d;
		end
	end

	// ==========================================================
	// link side: clock divider and frame sequencer

	assign tick    = (lk_half_q == div_q);
	assign fall    = tick & lk_sclk_q;
	assign lk_lane = lane_sel(lanes_q, pins_q);
	assign lk_sh_n = shift_in(lk_sh_q, d_s, lk_lane, pins_q);

	always_comb begin
		lk_st_d       = lk_st_q;
		lk_req_seen_d = lk_req_seen_q;
		lk_sclk_d     = lk_sclk_q;
		lk_cs_n_d     = lk_cs_n_q;
		lk_last_d     = lk_last_q;
		lk_word_tgl_d = lk_word_tgl_q;
		lk_done_tgl_d = lk_done_tgl_q;
		lk_bcnt_d     = lk_bcnt_q;
		lk_wcnt_d     = lk_wcnt_q;
		lk_hdr_d      = lk_hdr_q;
		lk_sh_d       = lk_sh_q;
		lk_word_d     = lk_word_q;
		lk_do_d       = lk_do_q;
		lk_oe_d       = lk_oe_q;
		// divider restarts so each phase begins with a full half
		if (tick || lk_st_q == qsfr_pkg::ST_IDLE ||
		    lk_st_q == qsfr_pkg::ST_HOLD) begin
			lk_half_d = 8'h00;
		end else begin
			lk_half_d = lk_half_q + 8'h01;
		end
		if (tick && (lk_st_q == qsfr_pkg::ST_HDR ||
		    lk_st_q == qsfr_pkg::ST_DUMMY || lk_st_q == qsfr_pkg::ST_DATA)) begin
			lk_sclk_d = ~lk_sclk_q;
		end
		unique case (lk_st_q)
			qsfr_pkg::ST_IDLE: begin
				lk_cs_n_d = `QSFR_CS_IDLE;
				lk_sclk_d = `QSFR_SCLK_IDLE;
				lk_oe_d   = 4'h0;
				if (req_s != lk_req_seen_q) begin
					lk_req_seen_d = req_s;
					lk_st_d       = qsfr_pkg::ST_SETUP;
					lk_cs_n_d     = 1'b0;
					lk_hdr_d      = {hdr_q[30:0], 1'b0};
					lk_do_d       = {3'h0, hdr_q[31]};
					lk_oe_d       = 4'h1;
					lk_bcnt_d     = 8'h00;
					lk_wcnt_d     = 12'h000;
					lk_sh_d       = '0;
				end
			end
			qsfr_pkg::ST_SETUP: begin
				if (tick) begin
					if (lk_bcnt_q == {5'h00, dly_q, 1'b0}) begin
						lk_sclk_d = 1'b1;
						lk_st_d   = qsfr_pkg::ST_HDR;
						lk_bcnt_d = 8'h00;
					end else begin
						lk_bcnt_d = lk_bcnt_q + 8'h01;
					end
				end
			end
			qsfr_pkg::ST_HDR: begin
				if (fall) begin
					if (lk_bcnt_q == `QSFR_HDR_LAST) begin
						lk_oe_d   = 4'h0;
						lk_do_d   = 4'h0;
						lk_bcnt_d = 8'h00;
						lk_st_d   = (dum_q == 4'h0) ? qsfr_pkg::ST_DATA :
						            qsfr_pkg::ST_DUMMY;
					end else begin
						lk_bcnt_d = lk_bcnt_q + 8'h01;
						lk_do_d   = {3'h0, lk_hdr_q[31]};
						lk_hdr_d  = {lk_hdr_q[30:0], 1'b0};
					end
				end
			end
			qsfr_pkg::ST_DUMMY: begin
				if (fall) begin
					if ((lk_bcnt_q + 8'h01) == {4'h0, dum_q}) begin
						lk_bcnt_d = 8'h00;
						lk_st_d   = qsfr_pkg::ST_DATA;
					end else begin
						lk_bcnt_d = lk_bcnt_q + 8'h01;
					end
				end
			end
			qsfr_pkg::ST_DATA: begin
				// flash launched at the prior fall
				if (fall) begin
					if ((lk_bcnt_q + lane_bits(lk_lane)) > {1'b0, len_q}) begin
						lk_word_d     = lk_sh_n;
						lk_last_d     = (lk_wcnt_q == cnt_q);
						lk_word_tgl_d = ~lk_word_tgl_q;
						lk_sh_d       = '0;
						lk_bcnt_d     = 8'h00;
						lk_st_d       = (lk_wcnt_q == cnt_q) ? qsfr_pkg::ST_END :
						                qsfr_pkg::ST_HOLD;
					end else begin
						lk_sh_d   = lk_sh_n;
						lk_bcnt_d = lk_bcnt_q + lane_bits(lk_lane);
					end
				end
			end
			qsfr_pkg::ST_HOLD: begin
				// clock parks low, select stays on
				if (ack_s == lk_word_tgl_q) begin
					lk_wcnt_d = lk_wcnt_q + 12'h001;
					lk_st_d   = qsfr_pkg::ST_DATA;
				end
			end
			qsfr_pkg::ST_END: begin
				if (tick) begin
					if (lk_bcnt_q == `QSFR_END_LAST) begin
						lk_cs_n_d     = `QSFR_CS_IDLE;
						lk_done_tgl_d = ~lk_done_tgl_q;
						lk_st_d       = qsfr_pkg::ST_IDLE;
					end else begin
						lk_bcnt_d = lk_bcnt_q + 8'h01;
					end
				end
			end
			default: begin
				lk_st_d   = qsfr_pkg::ST_IDLE;
				lk_cs_n_d = `QSFR_CS_IDLE;
				lk_sclk_d = `QSFR_SCLK_IDLE;
			end
		endcase
	end

	always_ff @(posedge link_clock or negedge rst_n) begin
		if (!rst_n) begin
			lk_st_q       <= qsfr_pkg::ST_IDLE;
			lk_req_seen_q <= 1'b0;
			lk_sclk_q     <= `QSFR_SCLK_IDLE;
			lk_cs_n_q     <= `QSFR_CS_IDLE;
			lk_last_q     <= 1'b0;
			lk_word_tgl_q <= 1'b0;
			lk_done_tgl_q <= 1'b0;
			lk_half_q     <= 8'h00;
			lk_bcnt_q     <= 8'h00;
			lk_wcnt_q     <= 12'h000;
			lk_hdr_q      <= 32'h0000_0000;
			lk_sh_q       <= '0;
			lk_word_q     <= '0;
			lk_do_q       <= 4'h0;
			lk_oe_q       <= 4'h0;
		end else begin
			lk_st_q       <= lk_st_d;
			lk_req_seen_q <= lk_req_seen_d;
			lk_sclk_q     <= lk_sclk_d;
			lk_cs_n_q     <= lk_cs_n_d;
			lk_last_q     <= lk_last_d;
			lk_word_tgl_q <= lk_word_tgl_d;
			lk_done_tgl_q <= lk_done_tgl_d;
			lk_half_q     <= lk_half_d;
			lk_bcnt_q     <= lk_bcnt_d;
			lk_wcnt_q     <= lk_wcnt_d;
			lk_hdr_q      <= lk_hdr_d;
			lk_sh_q       <= lk_sh_d;
			lk_word_q     <= lk_word_d;
			lk_do_q       <= lk_do_d;
			lk_oe_q       <= lk_oe_d;
		end
	end

	// ==========================================================
	// outputs
	assign busy          = busy_q;
	assign mm_ready      = ~busy_q;  // window read waits for the frame
	assign rx_word       = rx_word_q;
	assign rx_word_valid = rx_valid_q;
	assign word_irq      = word_irq_q;
	assign frame_irq     = frame_irq_q;
	assign mm_rvalid     = mm_rvalid_q;
	assign mm_rdata      = mm_rdata_q;
	assign cs_n          = lk_cs_n_q;
	assign sclk          = lk_sclk_q;
	assign d_o           = lk_do_q;
	assign d_oe          = lk_oe_q;

endmodule : qsfr_top

// File: qsfr_assertions.sv
// qsfr_assertions.sv: port timing checks for the serial read engine.
// assumes: bound to qsfr_top; config ports hold while busy is high.
module qsfr_checks (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        link_clock,
	input wire logic [1:0]  cs_to_data_delay_field,
	input wire logic [7:0]  clk_div,
	input wire logic        mm_req,
	input wire logic        busy,
	input wire logic        mm_ready,
	input wire logic        mm_rvalid,
	input wire logic        rx_word_valid,
	input wire logic        word_irq,
	input wire logic        frame_irq,
	input wire logic        cs_n,
	input wire logic        sclk,
	input wire logic [3:0]  d_o,
	input wire logic [3:0]  d_oe
);
	// ==========================================================
	// link cycle counters: since select, since the latest fall
	logic [11:0] sel_q, sel_d, fall_q, fall_d, lead_w, tail_w;
	logic        sclk_q, seen_q, seen_d;
	assign lead_w = 12'h2 * ({10'h0, cs_to_data_delay_field} + 12'h1)
		* ({4'h0, clk_div} + 12'h1);
	assign tail_w = 12'h4 * ({4'h0, clk_div} + 12'h1);
	// the fall count saturates so a long stall cannot wrap it; the select count wraps
	always_comb begin
		sel_d  = cs_n ? 12'h000 : sel_q + 12'h001;
		fall_d = (sclk_q && !sclk) ? 12'h001 : fall_q + {11'h0, ~&fall_q};
		seen_d = !cs_n && (seen_q || (sclk_q && !sclk));
	end
	always_ff @(posedge link_clock or negedge rst_n) begin
		if (!rst_n) begin
			sel_q  <= 12'h000;
			fall_q <= 12'h000;
			sclk_q <= 1'b0;
			seen_q <= 1'b0;
		end else begin
			sel_q  <= sel_d;
			fall_q <= fall_d;
			sclk_q <= sclk;
			seen_q <= seen_d;
		end
	end
	sequence first_fall_s;
		sclk_q && !sclk && !seen_q && !cs_n;
	endsequence
	sequence launch_s;
		!busy && mm_req;
	endsequence

	// ==========================================================
	// link side
	// select lead
	cs_lead_a: assert property (@(posedge link_clock)
		disable iff (!rst_n) first_fall_s |-> sel_q == lead_w)
		else $error("select to first fall time wrong");
	cs_release_a: assert property (@(posedge link_clock)
		disable iff (!rst_n) $rose(cs_n) |-> fall_q == tail_w)
		else $error("select release time wrong");
	sclk_idle_a: assert property (@(posedge link_clock)
		disable iff (!rst_n) cs_n |-> !sclk && d_oe == 4'h0)
		else $error("clock or data driven outside a frame");
	lines_used_a: assert property (@(posedge link_clock)
		disable iff (!rst_n) d_oe[3:1] == 3'h0)
		else $error("unused data line driven");
	d0_after_fall_a: assert property (@(posedge link_clock)
		disable iff (!rst_n)
		d_oe[0] && $past(d_oe[0]) && $changed(d_o[0]) |-> $fell(sclk))
		else $error("line zero changed away from a falling edge");

	// ==========================================================
	// system side
	// window ready
	ready_busy_a: assert property (@(posedge clock)
		disable iff (!rst_n) mm_ready == !busy)
		else $error("ready is not the inverse of busy");
	launch_busy_a: assert property (@(posedge clock)
		disable iff (!rst_n) launch_s |=> busy)
		else $error("window request not taken");
	rvalid_pair_a: assert property (@(posedge clock)
		disable iff (!rst_n) mm_rvalid |-> rx_word_valid)
		else $error("window data without a word");
	irq_word_a: assert property (@(posedge clock)
		disable iff (!rst_n) word_irq || frame_irq |-> rx_word_valid)
		else $error("event without a word");
	word_pulse_a: assert property (@(posedge clock)
		disable iff (!rst_n) rx_word_valid |=> !rx_word_valid)
		else $error("word pulse too long");
endmodule : qsfr_checks

// File: qsfr_flash_model.sv
// qsfr_flash_model.sv: behavioural serial flash answering reads.
// assumes: mode 0 link; d0 is the resolved level of line zero.
module qsfr_flash (
	input wire logic        cs_n,
	input wire logic        sclk,
	input wire logic        d0,
	input wire logic [3:0]  dummy,
	output logic     [3:0]  d_i,
	output logic     [31:0] hdr
);
	timeunit 1ns;
	timeprecision 1ns;
	int rises = 0;
	int falls = 0;
	initial d_i = 4'h5;
	initial hdr = 32'h0;
	// data pattern derived from the low address byte
	function automatic logic [3:0] nib(input logic [7:0] a, input int k);
		logic [7:0] t;
		t = a ^ 8'(k * 37 + (k >> 5));
		return t[5:2];
	endfunction : nib
	always @(posedge sclk) begin
		if (!cs_n && rises < 32) begin
			hdr = {hdr[30:0], d0};
			rises++;
		end
	end
	always @(negedge sclk) begin
		if (!cs_n) begin
			falls++;
			if (falls >= 32 + dummy)
				d_i <= nib(hdr[7:0], falls - 32 - int'(dummy));
			else
				d_i <= ~d_i;
		end
	end
	// released lines must not keep a stale value
	always @(cs_n) begin
		if (cs_n)
			d_i <= ~d_i;
		else begin
			rises = 0;
			falls = 0;
		end
	end
endmodule : qsfr_flash

// File: qsfr_top_test.sv
// qsfr_top_test.sv: self-checking bench for the serial read engine.
// assumes: qsfr_top, qsfr_flash and qsfr_checks are compiled first.
module qsfr_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic         clock = 1'b0, rst_n = 1'b0, link_clock = 1'b0;
	logic [1:0]   lane_mode = 2'h0, pin_mode = 2'h0;
	logic [1:0]   cs_to_data_delay_field = 2'h0;
	logic [6:0]   word_len_m1 = 7'h0;
	logic [11:0]  word_cnt_m1 = 12'h0;
	logic [7:0]   clk_div = 8'h1, sw_cmd = 8'h0, mm_cmd = 8'h0;
	logic [3:0]   dummy_cycles = 4'h0, d_o, d_oe, fd, line;
	logic         word_irq_en = 1'b0, frame_irq_en = 1'b0;
	logic         sw_start = 1'b0, mm_req = 1'b0;
	logic [23:0]  sw_addr = 24'h0, mm_addr = 24'h0;
	logic         busy, rx_word_valid, word_irq, frame_irq;
	logic         mm_ready, mm_rvalid, cs_n, sclk;
	logic [127:0] rx_word, got_q[$];
	logic [31:0]  mm_rdata, hdr_seen, mm_q[$];
	logic [1:0]   irq_q[$];
	int           seed = 19, n_fail = 0, n_compared = 0, j, ln;

	always #50 clock = ~clock;
	// 64 ns period; edges never meet the 100 ns clock's rising edges
	always #32 link_clock = ~link_clock;
	// wire level from the controller's enable; the flash drives the rest
	assign line = (d_oe & d_o) | (~d_oe & fd);

	qsfr_top DUT (.clock, .rst_n, .link_clock, .lane_mode, .pin_mode,
		.word_len_m1, .word_cnt_m1, .cs_to_data_delay_field, .clk_div,
		.dummy_cycles, .word_irq_en, .frame_irq_en, .sw_start, .sw_cmd,
		.sw_addr, .busy, .rx_word, .rx_word_valid, .word_irq, .frame_irq,
		.mm_cmd, .mm_req, .mm_addr, .mm_ready, .mm_rvalid, .mm_rdata,
		.cs_n, .sclk, .d_i(line), .d_o, .d_oe);
	qsfr_flash flash (.cs_n, .sclk, .d0(line[0]), .dummy(dummy_cycles),
		.d_i(fd), .hdr(hdr_seen));

	// ==========================================================
	// result capture: every output pulse stands one cycle, so look at
	// mid-cycle where it has settled rather than at its launch edge
	always @(negedge clock) begin
		if (rx_word_valid === 1'b1) begin
			got_q.push_back(rx_word);
			irq_q.push_back({word_irq, frame_irq});
		end
		if (mm_rvalid === 1'b1)
			mm_q.push_back(mm_rdata);
	end

	function automatic int rnd(input int n);
		return int'($unsigned($random(seed)) % n);
	endfunction : rnd

	task automatic chk(input string what, input logic [127:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic results;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results

	// ==========================================================
	// one frame: drive, wait, rebuild the words from the pattern
	task automatic frame(input int ln, pn, len, cnt, dd, dv, dc, mm);
		int k, b, s, i;
		logic [127:0] w, m;
		logic [3:0] n;
		logic [31:0] h;
		@(negedge clock);
		lane_mode = ln[1:0];
		pin_mode = pn[1:0];
		word_len_m1 = 7'(len - 1);
		word_cnt_m1 = 12'(cnt - 1);
		cs_to_data_delay_field = dd[1:0];
		clk_div = 8'(dv);
		dummy_cycles = dc[3:0];
		sw_cmd = 8'($random(seed));
		sw_addr = 24'($random(seed));
		mm_cmd = 8'($random(seed));
		mm_addr = 24'($random(seed));
		word_irq_en = mm ? 1'b0 : 1'(rnd(2));
		frame_irq_en = mm ? 1'b0 : 1'(rnd(2));
		sw_start = 1'b1;
		mm_req = 1'(mm);
		@(negedge clock);
		sw_start = 1'b0;
		mm_req = 1'b0;
		chk("busy", busy, 1);
		chk("ready", mm_ready, 0);
		for (i = 0; busy !== 1'b0 && i < 20000; i++)
			@(negedge clock);
		// a frame that never ends counts as a mismatch here
		chk("frame end", busy, 0);
		h = mm ? {mm_cmd, mm_addr} : {sw_cmd, sw_addr};
		chk("header", hdr_seen, h);
		if (mm) begin
			len = 32;
			cnt = 1;
		end
		b = ln == 2 ? 4 : ln == 1 ? 2 : 1;
		s = (len + b - 1) / b;
		m = ~128'h0 >> (128 - s * b);
		k = 0;
		chk("word count", got_q.size(), cnt);
		chk("window reads", mm_q.size(), mm);
		for (i = 0; i < cnt && got_q.size() > 0; i++) begin
			w = 128'h0;
			repeat (s) begin
				n = flash.nib(h[7:0], k);
				k++;
				w = (w << b) | (ln == 2 ? n : ln == 1 ? n[1:0] :
					pn == 0 ? n[0] : n[1]);
			end
			chk("rx word", got_q.pop_front() & m, w & m);
			chk("events", irq_q.pop_front(),
				{word_irq_en, frame_irq_en && i == cnt - 1});
			if (mm && mm_q.size() > 0)
				chk("window data", mm_q.pop_front(), w[31:0]);
		end
		got_q.delete();
		irq_q.delete();
		mm_q.delete();
	endtask : frame

	// ==========================================================
	// main sequence: edge lengths, all lane modes, window reads
	initial begin
		repeat (6) @(negedge clock);
		rst_n = 1'b1;
		repeat (2) @(negedge clock);
		frame(0, 0, 1, 1, 0, 1, 0, 0);
		frame(0, 1, 128, 2, 3, 1, 8, 0);
		frame(1, 2, 7, 3, 1, 2, 2, 0);
		frame(2, 2, 33, 3, 2, 1, 15, 0);
		for (j = 0; j < 3; j++)
			frame(j, j == 0 ? 1 : 2, 5, 2, j, 1, j * 4, 1);
		for (j = 0; j < 4; j++) begin
			ln = rnd(3);
			frame(ln, ln > 0 ? 2 : rnd(3), rnd(128) + 1, rnd(3) + 1,
				rnd(4), rnd(2) + 1, rnd(16), 0);
		end
		results;
	end

	// hang guard well past the longest expected run
	initial begin
		#6000000;
		n_fail++;
		results;
	end
endmodule : qsfr_top_test

bind qsfr_top qsfr_checks chk (.clock, .rst_n, .link_clock,
	.cs_to_data_delay_field, .clk_div, .mm_req, .busy, .mm_ready,
	.mm_rvalid, .rx_word_valid, .word_irq, .frame_irq, .cs_n, .sclk,
	.d_o, .d_oe);
